// [shared/rdwb_consts.svh]
// constants for the receive descriptor write-back and fetch block
`ifndef RDWB_CONSTS_SVH
`define RDWB_CONSTS_SVH
// register byte offsets
`define RDWB_OFF_CTRL 12'h000
`define RDWB_OFF_THRESH 12'h004
`define RDWB_OFF_TAIL 12'h008
`define RDWB_OFF_HBSIZE 12'h00c
`define RDWB_OFF_FETCH 12'h010
`define RDWB_OFF_CACHE 12'h014
`define RDWB_OFF_CONSUME 12'h018
// control register field positions
`define RDWB_CTRL_QEN 0
`define RDWB_CTRL_PCSD 1
`define RDWB_CTRL_IPPCSE 2
`define RDWB_CTRL_SBP 3
`define RDWB_CTRL_SECRC 4
`define RDWB_CTRL_EXTVLAN 5
`define RDWB_CTRL_DTYPE_LO 8
// status bit positions
`define RDWB_ST_DD 0
`define RDWB_ST_EOP 1
`define RDWB_ST_VP 3
`define RDWB_ST_UDP_CHECKSUM_CHECKED 4
`define RDWB_ST_L4I 5
`define RDWB_ST_IP_CHECKSUM_CHECKED 6
`define RDWB_ST_PIF 7
`define RDWB_ST_OUTER_VLAN_FOUND 9
`define RDWB_ST_UDP_FRAGMENT_SUM_VALID 10
`define RDWB_ST_LOW_LATENCY_IRQ_HIT 11
`define RDWB_ST_CRC 12
`define RDWB_ST_TIMESTAMP_IN_BUFFER 15
`define RDWB_ST_TS 16
// error bit positions
`define RDWB_ER_HBO 3
`define RDWB_ER_L4E 9
`define RDWB_ER_IPE 10
`define RDWB_ER_RXE 11
// misc values
`define RDWB_TS_BYTES 16'h0010
`define RDWB_DTYPE_REPL_LARGE 3'h4
`define RDWB_CACHE_DEPTH 8'h20
`define RDWB_LINE_DESC 8'h08
`define RDWB_RST_CTRL 32'h0000_0000
`define RDWB_RST_THRESH 32'h0000_0000
`endif

// [shared/rdwb_pkg.sv]
// types for the receive descriptor write-back and fetch block
package rdwb_pkg;
  // per-packet facts from the parser
  typedef struct packed {
    logic firstDesc;
    logic lastDesc;
    logic [15:0] ipId;
    logic [15:0] fragSum;
    logic [31:0] rssHash;
    logic vlanTagged;
    logic udpChecked;
    logic l4Checked;
    logic l4Failed;
    logic ipChecked;
    logic ipFailed;
    logic rxError;
    logic badPacket;
    logic passedInexact;
    logic outerVlan;
    logic firstFragUdpV4;
    logic fragmented;
    logic udpSumNonZero;
    logic lowLatencyHit;
    logic timeSyncCaptured;
    logic tsInBuffer;
    logic splitMode;
    logic replMode;
    logic [9:0] headerLength;
    logic [15:0] bufferBytes;
    logic [15:0] totalLength;
  } rdwb_pkt_t;
  // descriptor write-back words
  typedef struct packed {
    logic [31:0] hashOrFrag;
    logic [19:0] status;
    logic [11:0] errors;
    logic [15:0] length;
    logic [9:0] headerLength;
    logic splitHeaderValid;
  } rdwb_wb_t;
endpackage : rdwb_pkg

// [hdl/rdwb_engine.sv]
// receive descriptor write-back field builder and fetch decision logic
// Overview of operation
// - ip id in 47:32 when fragment sum mode
// - hash select puts 32-bit hash in word
// - last descriptor gets full 20-bit status
// - non-last descriptor: only done bit set
// - reserved status bits always written zero
// - bit 16 marks time-sync stamp captured
// - bit 15 marks timestamp placed in buffer
// - bit 5 marks l4 check, last only
// - error bit 9 on failed l4 check
// - bit 9 outer vlan, double vlan enabled
// - bit 10 only first udp v4 fragment
// - bit 11 marks low latency interrupt hit
// - bit 12 marks crc stripped per control
// - 12-bit error field with fixed positions
// - replication: overflow flag, still replicate up
// - split: overflow flag, unsplit, true length
// - rxe and ipe errors only with store-bad-packets set
// - 16-bit buffer byte count including crc
// - type 4 small packet reports full length
// - fetch on tail move or prefetch threshold
// - align partial fetches to cache lines
// - 10-bit header length, first descriptor only
// - fragment sum in bits 63:48
`timescale 1ns/1ps
`include "rdwb_consts.svh"
module rdwb_engine (
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // descriptor completion from the receive path
  input wire logic pktValid,
  input wire rdwb_pkg::rdwb_pkt_t pktInfo,
  output rdwb_pkg::rdwb_wb_t wbOut,
  output logic wbValid,
  // fetch request towards host memory
  output logic fetchReq,
  output logic [7:0] fetchCount,
  input wire logic fetchDone
);
  import rdwb_pkg::*;

  // whole module state
  typedef struct packed {
    logic awReady;
    logic wReady;
    logic [11:0] awAddr;
    logic awHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHave;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] ctrl;
    logic [31:0] thresh;
    logic [15:0] tail;
    logic [15:0] head;
    logic [9:0] hbSize;
    logic [7:0] cacheCount;
    logic [7:0] fetchPos;
    logic fetchReq;
    logic [7:0] fetchCount;
    rdwb_wb_t wb;
    logic wbValid;
  } rdwb_state_t;

  rdwb_state_t cur; // registered state
  rdwb_state_t next_cur; // next state

  // byte-lane merge for register writes
  function automatic logic [31:0] rdwb_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : rdwb_merge

  // ring distance between tail and head
  function automatic logic [15:0] rdwb_dist(input logic [15:0] t, input logic [15:0] h);
    return 16'(t - h);
  endfunction : rdwb_dist

  // control field taps
  logic qEnable; // queue enable
  logic hashSel; // hash instead of fragment sum
  logic ipSumEn; // ip payload sum enable
  logic storeBad; // store bad packets
  logic stripCrc; // crc strip control
  logic dblVlan; // double vlan enable
  logic [2:0] descFmt; // descriptor format select
  logic [7:0] preThresh; // prefetch threshold
  logic [7:0] hostThresh; // host threshold
  logic [15:0] hostAvail; // descriptors in host memory
  logic [7:0] cacheRoom; // free cache slots
  logic [7:0] toLine; // count to next line boundary
  logic overflow; // header exceeds header buffer
  always_comb
  begin
    qEnable = cur.ctrl[`RDWB_CTRL_QEN];
    hashSel = cur.ctrl[`RDWB_CTRL_PCSD];
    ipSumEn = cur.ctrl[`RDWB_CTRL_IPPCSE];
    storeBad = cur.ctrl[`RDWB_CTRL_SBP];
    stripCrc = cur.ctrl[`RDWB_CTRL_SECRC];
    dblVlan = cur.ctrl[`RDWB_CTRL_EXTVLAN];
    descFmt = cur.ctrl[`RDWB_CTRL_DTYPE_LO +: 3];
    preThresh = cur.thresh[7:0];
    hostThresh = cur.thresh[15:8];
    hostAvail = rdwb_dist(cur.tail, cur.head);
    cacheRoom = 8'(`RDWB_CACHE_DEPTH - cur.cacheCount);
    toLine = 8'(`RDWB_LINE_DESC - (cur.fetchPos & 8'(`RDWB_LINE_DESC - 8'h01)));
    overflow = pktInfo.headerLength > cur.hbSize;
  end

  // next-state logic: bus slave, write-back builder, fetch planner
  always_comb
  begin
    logic [31:0] wr;
    logic [7:0] want;
    logic [19:0] st;
    logic [11:0] er;
    logic [15:0] len;
    wr = 32'h0000_0000;
    want = 8'h00;
    st = 20'h00000;
    er = 12'h000;
    len = 16'h0000;
    next_cur = cur;
    // write address and data taken in either order
    if (s_axi_awvalid && cur.awReady)
    begin
      next_cur.awAddr = s_axi_awaddr;
      next_cur.awHave = 1'b1;
      next_cur.awReady = 1'b0;
    end
    if (s_axi_wvalid && cur.wReady)
    begin
      next_cur.wData = s_axi_wdata;
      next_cur.wStrb = s_axi_wstrb;
      next_cur.wHave = 1'b1;
      next_cur.wReady = 1'b0;
    end
    // perform the write once both halves held
    if (cur.awHave && cur.wHave && !cur.bValid)
    begin
      next_cur.bValid = 1'b1;
      next_cur.bResp = 2'b00;
      next_cur.awHave = 1'b0;
      next_cur.wHave = 1'b0;
      case (cur.awAddr)
        `RDWB_OFF_CTRL: next_cur.ctrl = rdwb_merge(cur.ctrl, cur.wData, cur.wStrb);
        `RDWB_OFF_THRESH: next_cur.thresh = rdwb_merge(cur.thresh, cur.wData, cur.wStrb);
        `RDWB_OFF_TAIL:
        begin
          wr = rdwb_merge({16'h0000, cur.tail}, cur.wData, cur.wStrb);
          next_cur.tail = wr[15:0];
        end
        `RDWB_OFF_HBSIZE:
        begin
          wr = rdwb_merge({22'h000000, cur.hbSize}, cur.wData, cur.wStrb);
          next_cur.hbSize = wr[9:0];
        end
        `RDWB_OFF_CONSUME:
        begin
          // software-side stand-in for descriptors used from the cache
          if (cur.cacheCount >= cur.wData[7:0])
          begin
            next_cur.cacheCount = 8'(cur.cacheCount - cur.wData[7:0]);
          end
          else
          begin
            next_cur.cacheCount = 8'h00;
          end
        end
        default: next_cur.bResp = 2'b10; // unmapped or read-only address
      endcase
    end
    // write response retires
    if (cur.bValid && s_axi_bready)
    begin
      next_cur.bValid = 1'b0;
      next_cur.awReady = 1'b1;
      next_cur.wReady = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && cur.arReady)
    begin
      next_cur.arReady = 1'b0;
      next_cur.rValid = 1'b1;
      next_cur.rResp = 2'b00;
      case (s_axi_araddr)
        `RDWB_OFF_CTRL: next_cur.rData = cur.ctrl;
        `RDWB_OFF_THRESH: next_cur.rData = cur.thresh;
        `RDWB_OFF_TAIL: next_cur.rData = {16'h0000, cur.tail};
        `RDWB_OFF_HBSIZE: next_cur.rData = {22'h000000, cur.hbSize};
        `RDWB_OFF_FETCH: next_cur.rData = {16'h0000, cur.head};
        `RDWB_OFF_CACHE: next_cur.rData = {15'h0000, cur.fetchReq, cur.fetchCount,
                                           cur.cacheCount};
        `RDWB_OFF_CONSUME: next_cur.rData = 32'h0000_0000;
        default:
        begin
          next_cur.rData = 32'h0000_0000;
          next_cur.rResp = 2'b10;
        end
      endcase
    end
    if (cur.rValid && s_axi_rready)
    begin
      next_cur.rValid = 1'b0;
      next_cur.arReady = 1'b1;
    end

    // descriptor write-back
    next_cur.wbValid = 1'b0;
    if (pktValid)
    begin
      next_cur.wbValid = 1'b1;
      st[`RDWB_ST_DD] = 1'b1;
      // reserved bits 2,8,13,14,17-19 never assigned
      if (pktInfo.lastDesc)
      begin
        st[`RDWB_ST_EOP] = 1'b1;
        st[`RDWB_ST_VP] = pktInfo.vlanTagged;
        st[`RDWB_ST_UDP_CHECKSUM_CHECKED] = pktInfo.udpChecked;
        st[`RDWB_ST_L4I] = pktInfo.l4Checked;
        st[`RDWB_ST_IP_CHECKSUM_CHECKED] = pktInfo.ipChecked;
        st[`RDWB_ST_PIF] = pktInfo.passedInexact;
        st[`RDWB_ST_OUTER_VLAN_FOUND] = pktInfo.outerVlan && dblVlan;
        st[`RDWB_ST_UDP_FRAGMENT_SUM_VALID] = pktInfo.firstFragUdpV4 && pktInfo.fragmented
                            && pktInfo.udpSumNonZero;
        st[`RDWB_ST_LOW_LATENCY_IRQ_HIT] = pktInfo.lowLatencyHit;
        st[`RDWB_ST_CRC] = stripCrc;
        st[`RDWB_ST_TIMESTAMP_IN_BUFFER] = pktInfo.tsInBuffer;
        st[`RDWB_ST_TS] = pktInfo.timeSyncCaptured;
        if (storeBad && pktInfo.badPacket)
        begin
          er[`RDWB_ER_RXE] = pktInfo.rxError;
          er[`RDWB_ER_IPE] = pktInfo.ipFailed;
        end
        er[`RDWB_ER_L4E] = pktInfo.l4Checked && pktInfo.l4Failed;
      end
      // overflow only meaningful with split header
      if ((pktInfo.splitMode || pktInfo.replMode) && pktInfo.firstDesc && overflow)
      begin
        er[`RDWB_ER_HBO] = 1'b1;
      end
      // byte count
      len = pktInfo.bufferBytes;
      if (descFmt == `RDWB_DTYPE_REPL_LARGE && pktInfo.totalLength < {6'h00, cur.hbSize})
      begin
        len = pktInfo.totalLength;
      end
      if (pktInfo.tsInBuffer && pktInfo.firstDesc)
      begin
        len = 16'(len + `RDWB_TS_BYTES);
      end
      next_cur.wb.status = st;
      next_cur.wb.errors = er;
      next_cur.wb.length = len;
      // true header length even when left unsplit
      next_cur.wb.headerLength = pktInfo.firstDesc ? pktInfo.headerLength : 10'h000;
      next_cur.wb.splitHeaderValid = pktInfo.firstDesc
                                     && (pktInfo.splitMode || pktInfo.replMode);
      if (hashSel)
      begin
        next_cur.wb.hashOrFrag = pktInfo.rssHash;
      end
      else if (ipSumEn)
      begin
        next_cur.wb.hashOrFrag = {pktInfo.fragSum, pktInfo.ipId};
      end
      else
      begin
        next_cur.wb.hashOrFrag = 32'h0000_0000;
      end
    end

    // fetch planner
    if (cur.fetchReq)
    begin
      if (fetchDone)
      begin
        next_cur.fetchReq = 1'b0;
        next_cur.head = 16'(cur.head + {8'h00, cur.fetchCount});
        next_cur.fetchPos = 8'(cur.fetchPos + cur.fetchCount);
        next_cur.cacheCount = 8'(next_cur.cacheCount + cur.fetchCount);
      end
    end
    else if (qEnable && hostAvail != 16'h0000 && cacheRoom != 8'h00)
    begin
      // counts are descriptors, not bus splits
      want = (hostAvail > {8'h00, cacheRoom}) ? cacheRoom : hostAvail[7:0];
      if (hostAvail > {8'h00, cacheRoom} && toLine < want)
      begin
        want = toLine;
      end
      if (cur.cacheCount == 8'h00
          || (cur.cacheCount <= preThresh && hostAvail >= {8'h00, hostThresh}))
      begin
        next_cur.fetchReq = 1'b1;
        next_cur.fetchCount = want;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.awReady <= 1'b1;
      cur.wReady <= 1'b1;
      cur.arReady <= 1'b1;
      cur.ctrl <= `RDWB_RST_CTRL;
      cur.thresh <= `RDWB_RST_THRESH;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // outputs straight from state flops
  assign s_axi_awready = cur.awReady;
  assign s_axi_wready = cur.wReady;
  assign s_axi_bvalid = cur.bValid;
  assign s_axi_bresp = cur.bResp;
  assign s_axi_arready = cur.arReady;
  assign s_axi_rvalid = cur.rValid;
  assign s_axi_rdata = cur.rData;
  assign s_axi_rresp = cur.rResp;
  assign wbOut = cur.wb;
  assign wbValid = cur.wbValid;
  assign fetchReq = cur.fetchReq;
  assign fetchCount = cur.fetchCount;

  // checks
  property p_hash;
    @(posedge clk) disable iff (!rst_n)
    pktValid && hashSel |=> wbOut.hashOrFrag == $past(pktInfo.rssHash);
  endproperty
  a_hash: assert property (p_hash) else $error("hash not written");
  property p_ipid;
    @(posedge clk) disable iff (!rst_n)
    pktValid && !hashSel && ipSumEn |=> wbOut.hashOrFrag[15:0] == $past(pktInfo.ipId);
  endproperty
  a_ipid: assert property (p_ipid) else $error("ip id not written");
  property p_nonlast;
    @(posedge clk) disable iff (!rst_n)
    pktValid && !pktInfo.lastDesc |=> wbValid && wbOut.status == 20'h00001;
  endproperty
  a_nonlast: assert property (p_nonlast) else $error("non-last status wrong");
  property p_rsvd;
    @(posedge clk) disable iff (!rst_n)
    wbValid |-> (wbOut.status & 20'he6104) == 20'h00000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status set");
  property p_outer_vlan_found;
    @(posedge clk) disable iff (!rst_n)
    wbValid && wbOut.status[`RDWB_ST_OUTER_VLAN_FOUND] |-> $past(dblVlan);
  endproperty
  a_outer_vlan_found: assert property (p_outer_vlan_found) else $error("outer vlan without enable");
  property p_l4e;
    @(posedge clk) disable iff (!rst_n)
    pktValid && pktInfo.lastDesc && pktInfo.l4Checked && pktInfo.l4Failed
    |=> wbOut.errors[`RDWB_ER_L4E];
  endproperty
  a_l4e: assert property (p_l4e) else $error("l4 error missing");
  property p_crc;
    @(posedge clk) disable iff (!rst_n)
    pktValid && pktInfo.lastDesc |=> wbOut.status[`RDWB_ST_CRC] == $past(stripCrc);
  endproperty
  a_crc: assert property (p_crc) else $error("crc strip flag wrong");
  property p_tslen;
    @(posedge clk) disable iff (!rst_n)
    pktValid && pktInfo.firstDesc && pktInfo.tsInBuffer && descFmt != `RDWB_DTYPE_REPL_LARGE
    |=> wbOut.length == 16'($past(pktInfo.bufferBytes) + `RDWB_TS_BYTES);
  endproperty
  a_tslen: assert property (p_tslen) else $error("timestamp length wrong");
  sequence s_empty_ready;
    !fetchReq && qEnable && cur.cacheCount == 8'h00 && hostAvail != 16'h0000;
  endsequence
  property p_fetch;
    @(posedge clk) disable iff (!rst_n)
    s_empty_ready |=> fetchReq ##0 fetchCount != 8'h00;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch on empty cache");
endmodule : rdwb_engine

// [verification/rdwb_fetch_host.sv]
// stand-in for host memory answering descriptor fetch requests
`timescale 1ns/1ps
module rdwb_fetch_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetchReq,
  input wire logic slow,
  output logic fetchDone
);
  logic [3:0] waitCnt; // cycles spent on the open request
  // one done pulse per request, after 2 or 13 cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetchDone <= 1'b0;
      waitCnt <= 4'h0;
    end
    else
    begin
      fetchDone <= 1'b0;
      // skip the edge where the engine still shows the finished request
      if (fetchReq && !fetchDone)
      begin
        if (waitCnt >= (slow ? 4'hc : 4'h1))
        begin
          fetchDone <= 1'b1;
          waitCnt <= 4'h0;
        end
        else
          waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : rdwb_fetch_host

// [verification/rdwb_tb_top.sv]
// self-checking bench for the descriptor write-back and fetch engine
`timescale 1ns/1ps
module rdwb_tb_top;
  import rdwb_pkg::*;
  logic clk, rst_n, slow;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic pktValid, wbValid, fetchReq, fetchDone;
  logic [7:0] fetchCount;
  rdwb_pkt_t pktInfo;
  rdwb_wb_t wbOut, x;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] ctrl, hbSize; // settings the expectation uses
  rdwb_wb_t expQ[$]; // expected write-backs, oldest first
  logic firstQ[$]; // header length valid per note

  rdwb_engine i_rdwb_engine (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pktValid(pktValid), .pktInfo(pktInfo), .wbOut(wbOut),
    .wbValid(wbValid), .fetchReq(fetchReq), .fetchCount(fetchCount),
    .fetchDone(fetchDone));

  rdwb_fetch_host i_rdwb_fetch_host (.clk(clk), .rst_n(rst_n), .fetchReq(fetchReq),
    .slow(slow), .fetchDone(fetchDone));

  // 250 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // axi4-lite write, response code expected okay up to offset 018h, error above
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    while (bready);
    chk("bresp", (a > 12'h018) ? 32'h2 : 32'h0, {30'h0, r});
  endtask : wr

  // axi4-lite read, masked data compare
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
    input string n);
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    while (rready);
    chk(n, e, d & m);
    chk("rresp", (a > 12'h018) ? 32'h2 : 32'h0, {30'h0, r});
  endtask : rd

  // wait a bounded time for the fetch request level
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (fetchReq !== lvl && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk("fetchReq", {31'h0, lvl}, {31'h0, fetchReq});
  endtask : wait_req

  // expected write-back from packet facts and settings
  function automatic rdwb_wb_t expect_wb(input rdwb_pkt_t p);
    rdwb_wb_t w;
    w = '0;
    // neither hash nor fragment sum enabled leaves the word at zero
    w.hashOrFrag = ctrl[1] ? p.rssHash
                 : (ctrl[2] ? {p.fragSum, p.ipId} : 32'h0000_0000);
    w.status[0] = 1'b1;
    if (p.lastDesc)
    begin
      w.status[1] = 1'b1;
      w.status[3] = p.vlanTagged;
      w.status[4] = p.udpChecked;
      w.status[5] = p.l4Checked;
      w.status[6] = p.ipChecked;
      w.status[7] = p.passedInexact;
      w.status[9] = p.outerVlan & ctrl[5];
      w.status[10] = p.firstFragUdpV4 & p.udpSumNonZero;
      w.status[11] = p.lowLatencyHit;
      w.status[12] = ctrl[4];
      w.status[15] = p.tsInBuffer;
      w.status[16] = p.timeSyncCaptured;
    end
    w.errors[11] = p.rxError & ctrl[3];
    w.errors[10] = p.ipFailed & ctrl[3];
    w.errors[9] = p.l4Failed;
    w.errors[3] = p.firstDesc & (p.splitMode | p.replMode) & (p.headerLength > hbSize[9:0]);
    w.headerLength = p.headerLength;
    w.splitHeaderValid = p.firstDesc & (p.splitMode | p.replMode);
    if (ctrl[10:8] == 3'h4 && p.firstDesc && p.totalLength < hbSize[15:0])
      w.length = p.totalLength;
    else
      w.length = p.bufferBytes + ((p.firstDesc && p.tsInBuffer) ? 16'h0010 : 16'h0000);
    return w;
  endfunction : expect_wb

  // one settings phase with a stream of random descriptors
  task automatic run_phase(input logic [31:0] c, input string nm);
    rdwb_pkt_t p;
    logic [127:0] r;
    logic v;
    ctrl = c;
    hbSize = 32'h40 + ($urandom % 256);
    wr(12'h000, ctrl);
    wr(12'h00c, hbSize);
    rd(12'h000, ctrl, 32'h0000_073f, "ctrl");
    rd(12'h00c, hbSize, 32'h0000_03ff, "header size");
    for (int i = 0; i < 48; i++)
    begin
      r = {$urandom, $urandom, $urandom, $urandom};
      p = r[$bits(rdwb_pkt_t)-1:0];
      p.fragmented = p.fragmented | p.firstFragUdpV4;
      p.l4Failed = p.l4Failed & p.l4Checked;
      if (!p.lastDesc) {p.l4Failed, p.rxError, p.ipFailed} = 3'b000;
      p.badPacket = p.rxError | p.ipFailed;
      if (p.splitMode) p.replMode = 1'b0;
      if (c[10])
      begin
        p.tsInBuffer = 1'b0;
        p.firstDesc = 1'b1;
        p.totalLength = 16'($urandom % 400);
      end
      v = ($urandom % 4) != 0;
      pktInfo <= p;
      pktValid <= v;
      if (v)
      begin
        expQ.push_back(expect_wb(p));
        firstQ.push_back(p.firstDesc);
      end
      @(posedge clk);
    end
    pktValid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pending write-backs", 0, expQ.size());
    $display("test %s done", nm);
  endtask : run_phase

  // write-back watcher
  always @(negedge clk)
  begin
    if (wbValid === 1'b1)
    begin
      if (expQ.size() == 0)
        chk("unexpected wbValid", 0, 1);
      else
      begin
        x = expQ.pop_front();
        chk("hash word", x.hashOrFrag, wbOut.hashOrFrag);
        chk("status", x.status, wbOut.status);
        chk("errors", x.errors, wbOut.errors);
        chk("length", x.length, wbOut.length);
        chk("split header", {31'h0, x.splitHeaderValid}, {31'h0, wbOut.splitHeaderValid});
        if (firstQ.pop_front())
          chk("header length", x.headerLength, wbOut.headerLength);
      end
    end
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    slow = 1'b1;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    pktValid = 1'b0;
    pktInfo = '0;
    ctrl = '0;
    hbSize = '0;
    void'($urandom(72448));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // fetch: queue off, then on with an empty cache
    wr(12'h004, 32'h0000_0108);
    wr(12'h008, 32'h0000_0005);
    repeat (10) @(posedge clk);
    chk("fetch while disabled", 0, {31'h0, fetchReq});
    wr(12'h000, 32'h0000_0001);
    wait_req(1'b1);
    chk("fetchCount", 32'h5, {24'h0, fetchCount});
    wait_req(1'b0);
    rd(12'h014, 32'h0000_0005, 32'h0001_00ff, "cache count");
    rd(12'h010, 32'h0000_0005, 32'h0000_ffff, "fetched head");
    // prefetch with more host descriptors than cache room
    slow <= 1'b0;
    wr(12'h008, 32'h0000_003c);
    wait_req(1'b1);
    chk("fetch alignment", 0, {29'h0, fetchCount[2:0] + 3'h5});
    chk("fetch room", 1, {31'h0, fetchCount <= 8'h1b && fetchCount != 8'h00});
    wait_req(1'b0);
    rd(12'h0ff, 32'h0, 32'hffff_ffff, "unmapped read");
    wr(12'h0ff, 32'h0000_0001);
    $display("test fetch done");
    run_phase(32'h0000_0005, "fragment sum");
    run_phase(32'h0000_003b, "hash store bad");
    run_phase(32'h0000_002d, "fragment store bad");
    run_phase(32'h0000_0417, "type four");
    run_phase(32'h0000_0011, "neither hash nor sum");
    tally_and_finish();
  end
endmodule : rdwb_tb_top
